/* File: src/sst_top.sv */
// Module: code self-test register block with Wishbone slave and fault flags
//
// Notes on behaviour
// - Parity coverage per position index; p64 covers 65..71.
// - Encode: bytes give d0..d63, nine bytes codeword.
// - Auto mode uses built-in pattern, ignores inputs.
// - Error type bit: 1 double, 0 single.
// - Direction bit: 1 encoder, 0 decoder.
// - Each run's outcome lands in output bytes.
// - Manual mode uses written input bytes.
// - Manual mode uses the memory path's code.
// - Decoder test sets matching flag, none if clean.
// - Encoder test leaves both flags unchanged.
// - Test runs only while enable is one.
// - Manual encoder output is codeword of written data.
// - Auto results: single flag, double zero, constant.
// - p0 is parity over whole 72-bit block.
// - p1 odd positions; higher parity by index bit.
// - Parity at 0,1,2,4,..64; data fills rest.
// - 64 data bits plus 8 parity bits.
//
// Chosen here: the Wishbone register port and the register offsets.
`default_nettype none
module sst_top
  import sst_pkg::*;
(
  input wire logic clk_i, // 200 MHz system clock
  input wire logic rstn_i, // Asynchronous reset, active low
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write enable
  input wire logic [7:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte lane selects
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Acknowledge
  output logic single_error_flag_o, // Sticky single-error flag
  output logic double_error_flag_o // Sticky double-error flag
);
  logic [1:0] rst_sync_r;
  logic rstn_s;
  logic ack_r;
  logic [31:0] dat_r;
  logic [SST_CTRL_W-1:0] ctrl_r;
  logic [7:0] in_r [SST_NUM_IN];
  logic [71:0] out_r;
  logic sec_r;
  logic ded_r;
  logic [71:0] in_word;
  logic [71:0] result;
  logic [31:0] rd_nxt;
  logic req;
  logic wr_go;
  logic en;
  logic manual;
  logic encode;
  logic dbl_sel;
  logic set_sec;
  logic set_ded;
  logic clr_sec;
  logic clr_ded;

  sst_codec_if cif ();

  sst_codec u_codec (
    .cif(cif.codec)
  );

  // Parity of the built-in encoder operand, worked out once at elaboration
  function automatic logic [71:0] sst_ref_code(input logic [63:0] d);
    logic [71:0] cw;
    cw = sst_place(d);
    for (int k = 0; k < SST_PAR_N; k++) begin
      for (int pos = 1; pos < SST_CODE_W; pos++) begin
        if (((pos >> k) & 1) == 1 && pos != (1 << k)) begin
          cw[1 << k] = cw[1 << k] ^ cw[pos];
        end
      end
    end
    cw[0] = ^cw[71:1];
    return cw;
  endfunction

  // Fixed whitening; a healthy encoder then shows the auto signature exactly
  localparam logic [71:0] AUTO_ENC_MASK = SST_AUTO_ENC_CODE ^ sst_ref_code(SST_AUTO_ENC_DATA);

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rstn_s = rst_sync_r[1];

  // Control field decode
  assign en = ctrl_r[SST_CTRL_ENABLE];
  assign manual = ctrl_r[SST_CTRL_MANUAL];
  assign encode = ctrl_r[SST_CTRL_ENCODE];
  assign dbl_sel = ctrl_r[SST_CTRL_DOUBLE];

  // Bus request; a write lands on the edge that sees ack high
  assign req = wb_cyc_i && wb_stb_i;
  assign wr_go = req && wb_we_i && ack_r && wb_sel_i[0];

  // Gather the nine input bytes, byte 0 lowest
  always_comb begin
    in_word = '0;
    for (int i = 0; i < SST_NUM_IN; i++) begin
      in_word[i*8 +: 8] = in_r[i];
    end
  end

  // Operand selection: built-in pattern unless manual mode
  always_comb begin
    if (manual) begin
      cif.enc_data = in_word[63:0];
    end else begin
      cif.enc_data = encode ? SST_AUTO_ENC_DATA : SST_AUTO_DEC_DATA;
    end
  end

  // Auto decode flips bits of a clean codeword from the same encoder; kept apart
  // from the operand process so no process both feeds and reads the encoder
  always_comb begin
    if (manual) begin
      cif.dec_code = in_word;
    end else begin
      cif.dec_code = cif.enc_code ^ (dbl_sel ? SST_DED_MASK : SST_SEC_MASK);
    end
  end

  // Result picked by direction; decoder leaves the top byte zero, auto encode is whitened
  assign result = encode ? (manual ? cif.enc_code : cif.enc_code ^ AUTO_ENC_MASK) :
                  {8'h00, cif.dec_data};

  // Control register
  always_ff @(posedge clk_i or negedge rstn_s) begin
    if (!rstn_s) begin
      ctrl_r <= SST_CTRL_RST;
    end else if (wr_go && wb_adr_i == SST_OFS_CTRL) begin
      ctrl_r <= wb_dat_i[SST_CTRL_W-1:0];
    end
  end

  // Input byte registers, one word each
  always_ff @(posedge clk_i or negedge rstn_s) begin
    if (!rstn_s) begin
      for (int i = 0; i < SST_NUM_IN; i++) begin
        in_r[i] <= 8'h00;
      end
    end else begin
      for (int i = 0; i < SST_NUM_IN; i++) begin
        if (wr_go && wb_adr_i == SST_OFS_IN0 + 8'(4 * i)) begin
          in_r[i] <= wb_dat_i[7:0];
        end
      end
    end
  end

  // Outcome capture every cycle the test is on; holds once disabled
  always_ff @(posedge clk_i or negedge rstn_s) begin
    if (!rstn_s) begin
      out_r <= '0;
    end else if (en) begin
      out_r <= result;
    end
  end

  // Flag sets only from a running decoder test; clears only from writes to the flag clear register
  assign set_sec = en && !encode && cif.dec_single;
  assign set_ded = en && !encode && cif.dec_double;
  assign clr_sec = wr_go && wb_adr_i == SST_OFS_FLAG_CLR && wb_dat_i[SST_FLAG_SINGLE];
  assign clr_ded = wr_go && wb_adr_i == SST_OFS_FLAG_CLR && wb_dat_i[SST_FLAG_DOUBLE];

  // Sticky flags; a set in the clearing cycle wins so no event is lost
  always_ff @(posedge clk_i or negedge rstn_s) begin
    if (!rstn_s) begin
      sec_r <= 1'b0;
    end else begin
      sec_r <= set_sec || (sec_r && !clr_sec);
    end
  end

  always_ff @(posedge clk_i or negedge rstn_s) begin
    if (!rstn_s) begin
      ded_r <= 1'b0;
    end else begin
      ded_r <= set_ded || (ded_r && !clr_ded);
    end
  end

  assign single_error_flag_o = sec_r;
  assign double_error_flag_o = ded_r;

  // Read mux; unmapped and write-only addresses read as zero
  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (wb_adr_i == SST_OFS_CTRL) begin
      rd_nxt[SST_CTRL_W-1:0] = ctrl_r;
    end else if (wb_adr_i == SST_OFS_FLAGS) begin
      rd_nxt[SST_FLAG_SINGLE] = sec_r;
      rd_nxt[SST_FLAG_DOUBLE] = ded_r;
    end
    for (int i = 0; i < SST_NUM_IN; i++) begin
      if (wb_adr_i == SST_OFS_IN0 + 8'(4 * i)) begin
        rd_nxt[7:0] = in_r[i];
      end
    end
    for (int i = 0; i < SST_NUM_OUT; i++) begin
      if (wb_adr_i == SST_OFS_OUT0 + 8'(4 * i)) begin
        rd_nxt[7:0] = out_r[i*8 +: 8];
      end
    end
  end

  // One ack per request, dropped the cycle after; every address answers
  always_ff @(posedge clk_i or negedge rstn_s) begin
    if (!rstn_s) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req && !ack_r;
    end
  end

  // Read data loaded with ack so it is valid at the sampling edge
  always_ff @(posedge clk_i or negedge rstn_s) begin
    if (!rstn_s) begin
      dat_r <= 32'h0000_0000;
    end else if (req && !ack_r) begin
      dat_r <= rd_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  default clocking dc @(posedge clk_i);
  endclocking
  default disable iff (!rstn_s);

  AST_ENC_FLAGS_KEEP: assert property (
    (en && encode && !clr_sec && !clr_ded) |=> ($stable(sec_r) && $stable(ded_r)))
    else $error("encoder test changed an error flag");

  AST_SEC_SET: assert property (
    (en && !encode && cif.dec_single) |=> sec_r)
    else $error("single error not flagged");

  AST_DED_SET: assert property (
    (en && !encode && cif.dec_double) |=> (ded_r && !$rose(sec_r)))
    else $error("double error not flagged or single flag rose");

  AST_CLEAN_NO_FLAG: assert property (
    (!sec_r && !ded_r && en && !encode && !cif.dec_single && !cif.dec_double)
      |=> (!sec_r && !ded_r))
    else $error("flag set on clean operand");

  AST_AUTO_SEC: assert property (
    (en && !manual && !encode && !dbl_sel) |=> ##0 (sec_r && out_r[63:0] == SST_AUTO_DEC_DATA))
    else $error("auto single test result wrong");

  AST_AUTO_DED: assert property (
    (en && !manual && !encode && dbl_sel) |=> (ded_r && out_r == '0))
    else $error("auto double test result wrong");

  AST_MANUAL_ENC: assert property (
    (en && manual && encode) |=> (sst_extract(out_r) == $past(in_word[63:0])))
    else $error("encoder output does not carry written data");

  AST_IDLE_HOLD: assert property (
    (!en) |=> $stable(out_r))
    else $error("output changed with test disabled");

  AST_CLEAR_ONE: assert property (
    (clr_sec && !set_sec) |=> !sec_r)
    else $error("single flag not cleared by one");

  AST_DED_CLEAR: assert property (
    (clr_ded && !set_ded) |=> !ded_r)
    else $error("double flag not cleared by one");

  AST_AUTO_ENC: assert property (
    (en && !manual && encode) |=> (out_r == SST_AUTO_ENC_CODE))
    else $error("auto encoder signature wrong");

  AST_DEC_TOP: assert property (
    (en && !encode) |=> (out_r[71:64] == 8'h00))
    else $error("decoder result top byte not zero");

  AST_ACK_PULSE: assert property (
    (wb_ack_o) |=> (!wb_ack_o))
    else $error("ack held two cycles");

  COV_AUTO_ENC: cover property (en && !manual && encode ##1 en);
  COV_MAN_DEC_SEC: cover property (en && manual && !encode ##1 sec_r);
  COV_MAN_DEC_DED: cover property (en && manual && !encode ##1 ded_r);
  COV_CLEAR_RACE: cover property (clr_sec && set_sec);
  COV_MAN_ENC: cover property (en && manual && encode ##1 en);
endmodule // sst_top
`default_nettype wire

/* File: src/sst_pkg.sv */
// Package: register map, field layout and code constants of the code self-test
`default_nettype none
package sst_pkg;
  // Register byte offsets on the Wishbone port
  localparam logic [7:0] SST_OFS_CTRL = 8'h00;
  localparam logic [7:0] SST_OFS_FLAGS = 8'h04;
  localparam logic [7:0] SST_OFS_FLAG_CLR = 8'h08;
  localparam logic [7:0] SST_OFS_IN0 = 8'h10;
  localparam logic [7:0] SST_OFS_OUT0 = 8'h40;
  localparam int SST_NUM_IN = 9;
  localparam int SST_NUM_OUT = 9;

  // Control register fields
  localparam int SST_CTRL_ENABLE = 0;
  localparam int SST_CTRL_MANUAL = 1;
  localparam int SST_CTRL_ENCODE = 2;
  localparam int SST_CTRL_DOUBLE = 3;
  localparam int SST_CTRL_W = 4;
  localparam logic [3:0] SST_CTRL_RST = 4'h0;

  // Flag and flag clear fields
  localparam int SST_FLAG_SINGLE = 0;
  localparam int SST_FLAG_DOUBLE = 1;

  // Code geometry
  localparam int SST_DATA_W = 64;
  localparam int SST_CODE_W = 72;
  localparam int SST_PAR_N = 7;

  // Built-in operands and injected error patterns
  localparam logic [63:0] SST_AUTO_DEC_DATA = 64'h18C3_FF8A_68A9_8069;
  localparam logic [71:0] SST_AUTO_ENC_CODE = 72'hCD_3968_C140_2EA5_ED6D;
  localparam logic [71:0] SST_SEC_MASK = 72'h00_0000_0000_0000_0008;
  localparam logic [71:0] SST_DED_MASK = 72'h00_0000_0000_0000_0028;

  // Spread data bits d0..d63 over the non-parity positions, ascending
  function automatic logic [71:0] sst_place(input logic [63:0] d);
    logic [71:0] cw;
    int j;
    cw = '0;
    j = 0;
    for (int pos = 1; pos < SST_CODE_W; pos++) begin
      if ((pos & (pos - 1)) != 0) begin
        cw[pos] = d[j];
        j++;
      end
    end
    return cw;
  endfunction

  // Gather data bits d0..d63 back out of a codeword
  function automatic logic [63:0] sst_extract(input logic [71:0] cw);
    logic [63:0] d;
    int j;
    d = '0;
    j = 0;
    for (int pos = 1; pos < SST_CODE_W; pos++) begin
      if ((pos & (pos - 1)) != 0) begin
        d[j] = cw[pos];
        j++;
      end
    end
    return d;
  endfunction

  localparam logic [63:0] SST_AUTO_ENC_DATA = sst_extract(SST_AUTO_ENC_CODE);
endpackage
`default_nettype wire

/* File: src/sst_codec_if.sv */
// Interface: operand and result wires between the tester and the code engine
`default_nettype none
interface sst_codec_if;
  logic [63:0] enc_data;
  logic [71:0] enc_code;
  logic [71:0] dec_code;
  logic [63:0] dec_data;
  logic dec_single;
  logic dec_double;
  modport codec (input enc_data, input dec_code,
                 output enc_code, output dec_data, output dec_single, output dec_double);
  modport user (output enc_data, output dec_code,
                input enc_code, input dec_data, input dec_single, input dec_double);
endinterface
`default_nettype wire

/* File: src/sst_codec.sv */
// Module: combinational (72,64) single-correct double-detect encoder and decoder
`default_nettype none
module sst_codec
  import sst_pkg::*;
(
  sst_codec_if.codec cif // Operand in, results out
);
  // Encoder: Hamming parity on power-of-two positions, p0 over all
  always_comb begin
    logic [71:0] cw;
    logic p;
    cw = sst_place(cif.enc_data);
    p = 1'b0;
    for (int k = 0; k < SST_PAR_N; k++) begin
      p = 1'b0;
      for (int pos = 1; pos < SST_CODE_W; pos++) begin
        if (((pos >> k) & 1) == 1) begin
          p = p ^ cw[pos];
        end
      end
      cw[1 << k] = p;
    end
    cw[0] = ^cw[71:1];
    cif.enc_code = cw;
  end

  // Decoder: syndrome plus overall parity separates single from double
  always_comb begin
    logic [6:0] syn;
    logic ovr;
    logic [71:0] fixed;
    logic dbl;
    syn = 7'h00;
    dbl = 1'b0;
    ovr = ^cif.dec_code;
    fixed = cif.dec_code;
    for (int pos = 1; pos < SST_CODE_W; pos++) begin
      if (cif.dec_code[pos]) begin
        syn = syn ^ 7'(pos);
      end
    end
    // A syndrome past the last position cannot be a single flip
    dbl = (!ovr && syn != 7'h00) || (ovr && int'(syn) >= SST_CODE_W);
    if (ovr && !dbl) begin
      fixed[syn] = ~fixed[syn];
    end
    cif.dec_single = ovr && !dbl;
    cif.dec_double = dbl;
    cif.dec_data = dbl ? 64'h0000_0000_0000_0000 : sst_extract(fixed);
  end
endmodule // sst_codec
`default_nettype wire

/* File: test/tb.sv */
// Testbench: register-level checks of the code self-test block
`default_nettype none
module tb
  import sst_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_i, rstn_i, wb_cyc_i, wb_stb_i, wb_we_i;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic wb_ack_o, single_error_flag_o, double_error_flag_o;
  int error_cnt, compares;

`define CHK(nm, ex, gt) begin \
  compares++; \
  if ((gt) !== (ex)) begin \
    error_cnt++; \
    $display("mismatch %s exp %h got %h", nm, ex, gt); \
  end \
end

  sst_top i_dut (.clk_i(clk_i), .rstn_i(rstn_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .single_error_flag_o(single_error_flag_o),
    .double_error_flag_o(double_error_flag_o));

  // 200 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // Own reference encoder, kept apart from the design's helpers
  function automatic logic [71:0] ref_enc(input logic [63:0] d);
    logic [71:0] c;
    int j;
    c = '0;
    j = 0;
    for (int p = 1; p < 72; p++) begin
      if ((p & (p - 1)) != 0) begin
        c[p] = d[j];
        j++;
      end
    end
    for (int k = 0; k < 7; k++) begin
      for (int p = 1; p < 72; p++) begin
        if (p[k] && p != (1 << k)) begin
          c[1 << k] ^= c[p];
        end
      end
    end
    c[0] = ^c[71:1];
    return c;
  endfunction

  task automatic close_out;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // One classic Wishbone cycle; hang cut short by a bounded wait
  task automatic xfer(input logic [7:0] a, input logic w, input logic [3:0] s,
                      input logic [7:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= {24'h000000, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (wb_ack_o !== 1'b1) begin
      error_cnt++;
      $display("mismatch ack exp 1 got %b", wb_ack_o);
      close_out();
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    xfer(a, 1'b1, 4'hF, d, q);
  endtask

  task automatic chk_rd(input string nm, input logic [7:0] a, input logic [31:0] ex);
    logic [31:0] q;
    xfer(a, 1'b0, 4'hF, 8'h00, q);
    `CHK(nm, ex, q)
  endtask

  task automatic wr_in(input logic [71:0] v);
    for (int i = 0; i < 9; i++) wr(SST_OFS_IN0 + 8'(4 * i), v[8 * i +: 8]);
  endtask

  task automatic chk_out(input logic [71:0] ex);
    logic [71:0] v;
    logic [31:0] q;
    for (int i = 0; i < 9; i++) begin
      xfer(SST_OFS_OUT0 + 8'(4 * i), 1'b0, 4'hF, 8'h00, q);
      v[8 * i +: 8] = q[7:0];
    end
    `CHK("out bytes", ex, v)
  endtask

  // Disable, clear both flags, confirm they read clear
  task automatic prep;
    wr(SST_OFS_CTRL, 8'h00);
    wr(SST_OFS_FLAG_CLR, 8'h03);
    chk_rd("flags clr", SST_OFS_FLAGS, 32'h0);
  endtask

  // Configure first, then enable, then check flags and output bytes
  task automatic run(input logic [3:0] ctrl, input logic [1:0] fl, input logic [71:0] ex);
    wr(SST_OFS_CTRL, {4'h0, ctrl & 4'hE});
    wr(SST_OFS_CTRL, {4'h0, ctrl});
    chk_rd("flags", SST_OFS_FLAGS, {30'h0, fl});
    `CHK("flag pins", fl, {double_error_flag_o, single_error_flag_o})
    chk_out(ex);
  endtask

  initial begin
    logic [63:0] dt;
    logic [71:0] enc_auto;
    logic [71:0] msk [5];
    logic [1:0] fl [5];
    logic [3:0] ct [5];
    logic [31:0] q;
    dt = 64'h0123_4567_89AB_CDEF;
    enc_auto = 72'hCD_3968_C140_2EA5_ED6D;
    msk = '{72'h0, 72'h80_0000_0000_0000_0000, 72'h1, 72'h40_0000_0000_0000_0008,
            72'h01_0000_0000_0000_0002};
    fl = '{2'b00, 2'b01, 2'b01, 2'b10, 2'b10};
    ct = '{4'h3, 4'h3, 4'h3, 4'hB, 4'hB};
    {wb_cyc_i, wb_stb_i, wb_we_i} = 3'b000;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    error_cnt = 0;
    compares = 0;
    rstn_i = 1'b0;
    repeat (5) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk_rd("ctrl rst", SST_OFS_CTRL, 32'h0);
    chk_rd("flags rst", SST_OFS_FLAGS, 32'h0);
    chk_rd("out0 rst", SST_OFS_OUT0, 32'h0);
    wr(8'hFC, 8'hFF);
    chk_rd("unmapped", 8'hFC, 32'h0);
    // Junk operand so auto runs prove they ignore it
    wr_in({8'hA5, ~dt});
    chk_rd("in8", SST_OFS_IN0 + 8'h20, 32'hA5);
    prep();
    run(4'h1, 2'b01, {8'h00, 64'h18C3_FF8A_68A9_8069});
    // Clearing while the single test still runs: the fresh set wins
    wr(SST_OFS_FLAG_CLR, 8'h03);
    chk_rd("clr while on", SST_OFS_FLAGS, 32'h1);
    prep();
    run(4'h9, 2'b10, 72'h0);
    wr(SST_OFS_CTRL, 8'h00);
    run(4'h5, 2'b10, enc_auto);
    run(4'hD, 2'b10, enc_auto);
    wr(SST_OFS_CTRL, 8'h00);
    wr(SST_OFS_FLAG_CLR, 8'h00);
    chk_rd("clr zero", SST_OFS_FLAGS, 32'h2);
    wr(SST_OFS_FLAG_CLR, 8'h02);
    chk_rd("clr one", SST_OFS_FLAGS, 32'h0);
    xfer(SST_OFS_CTRL, 1'b1, 4'hE, 8'h0F, q);
    chk_rd("sel0 off", SST_OFS_CTRL, 32'h0);
    wr_in({8'h00, dt});
    run(4'h7, 2'b00, ref_enc(dt));
    // Outputs must hold while the test is off
    wr(SST_OFS_CTRL, 8'h06);
    wr_in({8'h00, ~dt});
    chk_out(ref_enc(dt));
    wr(SST_OFS_CTRL, 8'h07);
    chk_out(ref_enc(~dt));
    // Clean, single at top and at overall parity, then double errors
    for (int i = 0; i < 5; i++) begin
      prep();
      wr_in(ref_enc(dt) ^ msk[i]);
      run(ct[i], fl[i], fl[i] == 2'b10 ? 72'h0 : {8'h00, dt});
    end
    close_out();
  end
endmodule // tb
`default_nettype wire
